// ---- hw/tws_pkg.sv ----
// shared constants for the two-wire slave block
package tws_pkg;
    // ***************************************************
    // register offsets (index on the plain port)
    // ***************************************************
    localparam logic [2:0] OFS_DATA = 3'h0; // shift_data_reg
    localparam logic [2:0] OFS_STATUS = 3'h1; // bus_status_reg
    localparam logic [2:0] OFS_ADDR = 3'h2; // own_address_reg
    localparam logic [2:0] OFS_CTRL = 3'h3; // two_wire_control_reg
    localparam logic [2:0] OFS_SLEEP = 3'h4; // sleep control
    // ***************************************************
    // control fields
    // ***************************************************
    localparam int CTL_DONE = 7;
    localparam int CTL_ACKEN = 6;
    localparam int CTL_BEGIN = 5;
    localparam int CTL_HALT = 4;
    localparam int CTL_WCOL = 3;
    localparam int CTL_EN = 2;
    localparam int CTL_IRQEN = 0;
    localparam int ADR_GCE = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] ADDR_RESET = 8'hfe;
    localparam logic [7:0] DATA_RESET = 8'hff;
    localparam logic [6:0] GEN_CALL = 7'h00;
    // ***************************************************
    // status codes (prescaler bits zero)
    // ***************************************************
    localparam logic [7:0] ST_SR_ADDR = 8'h60;
    localparam logic [7:0] ST_SR_GC = 8'h70;
    localparam logic [7:0] ST_SR_DATA_ACK = 8'h80;
    localparam logic [7:0] ST_SR_DATA_NACK = 8'h88;
    localparam logic [7:0] ST_GC_DATA_ACK = 8'h90;
    localparam logic [7:0] ST_GC_DATA_NACK = 8'h98;
    localparam logic [7:0] ST_STOP = 8'ha0;
    localparam logic [7:0] ST_ST_ADDR = 8'ha8;
    localparam logic [7:0] ST_ST_ARB = 8'hb0;
    localparam logic [7:0] ST_ST_DATA_ACK = 8'hb8;
    localparam logic [7:0] ST_ST_DATA_NACK = 8'hc0;
    localparam logic [7:0] ST_ST_LAST_ACK = 8'hc8;
    localparam logic [7:0] ST_NONE = 8'hf8;
    // ***************************************************
    // link state machine
    // ***************************************************
    typedef enum logic [2:0] {
        LS_IDLE = 3'b000,
        LS_ADDR = 3'b001,
        LS_ADDR_ACK = 3'b010,
        LS_RX = 3'b011,
        LS_RX_ACK = 3'b100,
        LS_TX = 3'b101,
        LS_TX_ACK = 3'b110,
        LS_IGNORE = 3'b111
    } tws_link_type;
endpackage : tws_pkg

// ---- hw/tws_slave.sv ----
// two-wire slave: address match, receive end, transmit mode, sleep wake
//
// The address map and the plain strobed port are this design's own decisions.
module tws_slave (
    // system
    input wire logic mclk,
    input wire logic reset,
    // register port
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    // bus pins, enable low while driving low
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sclOut,
    output logic sclOeN,
    output logic sdaOut,
    output logic sdaOeN,
    // master side hooks
    input wire logic arbLost,
    output logic startRequest,
    output logic wakeUp
);
    import tws_pkg::*;

    // ***************************************************
    // pin synchronisers and edge detection
    // ***************************************************
    logic [1:0] sclSync_q, sdaSync_q;
    logic sclPrev_q, sdaPrev_q;
    // first stage feeds only the second stage
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sclSync_q <= 2'b11;
            sdaSync_q <= 2'b11;
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclSync_q <= {sclSync_q[0], sclIn};
            sdaSync_q <= {sdaSync_q[0], sdaIn};
            sclPrev_q <= sclSync_q[1];
            sdaPrev_q <= sdaSync_q[1];
        end
    end
    wire scl = sclSync_q[1];
    wire sda = sdaSync_q[1];
    wire sclRise = scl && !sclPrev_q;
    wire sclFall = !scl && sclPrev_q;
    wire startSeen = scl && sclPrev_q && !sda && sdaPrev_q;
    wire stopSeen = scl && sclPrev_q && sda && !sdaPrev_q;

    // ***************************************************
    // registers
    // ***************************************************
    logic [7:0] ctrl_q, addr_q, data_q, status_q;
    logic sleep_q, busBusy_q, stretch_q;
    logic lastByte_q, gcMode_q, wokeUp_q;
    tws_link_type state_q;
    logic [2:0] bitCnt_q;
    logic [7:0] shift_q;
    logic setDone;
    logic [7:0] setStatus;

    function automatic logic isReg(input logic [2:0] a, input logic [2:0] ofs);
        return a == ofs;
    endfunction : isReg

    wire doneClear = regWrite && isReg(regAddr, OFS_CTRL) && regWdata[CTL_DONE];
    wire enabled = ctrl_q[CTL_EN];
    wire ackEn = ctrl_q[CTL_ACKEN];
    wire ownHit = shift_q[7:1] == addr_q[7:1];
    wire gcHit = shift_q[7:1] == GEN_CALL && addr_q[ADR_GCE];
    // address and receive ack states span two falls; the count marks the second half, the ack bit itself
    wire ackPhase = bitCnt_q[0];

    // control register; hardware set of the flag beats software clear
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl_q <= CTRL_RESET;
        end else begin
            if (regWrite && isReg(regAddr, OFS_CTRL)) begin
                ctrl_q[6:0] <= {regWdata[6:4], ctrl_q[CTL_WCOL], regWdata[2:0]};
                if (regWdata[CTL_DONE]) begin
                    ctrl_q[CTL_DONE] <= 1'b0;
                end
            end
            if (regWrite && isReg(regAddr, OFS_DATA) && !ctrl_q[CTL_DONE]) begin
                ctrl_q[CTL_WCOL] <= 1'b1;
            end
            if (startRequest && !busBusy_q) begin
                ctrl_q[CTL_BEGIN] <= 1'b0; // start handed to master
            end
            if (setDone) begin
                ctrl_q[CTL_DONE] <= 1'b1;
            end
        end
    end

    // address and sleep registers
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            addr_q <= ADDR_RESET;
            sleep_q <= 1'b0;
        end else begin
            if (regWrite && isReg(regAddr, OFS_ADDR)) begin
                addr_q <= regWdata;
            end
            if (regWrite && isReg(regAddr, OFS_SLEEP)) begin
                sleep_q <= regWdata[0];
            end else if (wakeUp) begin
                sleep_q <= 1'b0; // address match ends sleep
            end
        end
    end

    // status code; 0xf8 while flag is clear
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            status_q <= ST_NONE;
        end else if (setDone) begin
            status_q <= setStatus;
        end else if (doneClear) begin
            status_q <= ST_NONE;
        end
    end

    // register read, one cycle later
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                OFS_DATA: regRdata <= data_q;
                OFS_STATUS: regRdata <= status_q;
                OFS_ADDR: regRdata <= addr_q;
                OFS_CTRL: regRdata <= ctrl_q;
                OFS_SLEEP: regRdata <= {7'h00, sleep_q};
                default: regRdata <= 8'h00;
            endcase
        end
    end

    // bus busy tracking for deferred start
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            busBusy_q <= 1'b0;
        end else if (startSeen) begin
            busBusy_q <= 1'b1;
        end else if (stopSeen) begin
            busBusy_q <= 1'b0;
        end
    end

    // start request waits for a free bus
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            startRequest <= 1'b0;
        end else begin
            startRequest <= enabled && ctrl_q[CTL_BEGIN] && !ctrl_q[CTL_DONE] && !busBusy_q && !startRequest;
        end
    end

    // ***************************************************
    // link state machine
    // ***************************************************
    // sleep path: the sampled bus clock still paces address shifting
    always_comb begin
        setDone = 1'b0;
        setStatus = ST_NONE;
        if (state_q == LS_ADDR_ACK && sclFall && ackPhase) begin
            setDone = 1'b1;
            if (shift_q[0]) begin
                setStatus = arbLost ? ST_ST_ARB : ST_ST_ADDR;
            end else begin
                setStatus = gcMode_q ? ST_SR_GC : ST_SR_ADDR;
            end
        end else if (state_q == LS_RX_ACK && sclFall && ackPhase) begin
            setDone = 1'b1;
            if (gcMode_q) begin
                setStatus = lastByte_q ? ST_GC_DATA_NACK : ST_GC_DATA_ACK;
            end else begin
                setStatus = lastByte_q ? ST_SR_DATA_NACK : ST_SR_DATA_ACK;
            end
        end else if (state_q == LS_TX_ACK && sclFall) begin
            setDone = 1'b1;
            if (shift_q[0]) begin
                setStatus = ST_ST_DATA_NACK;
            end else if (lastByte_q) begin
                setStatus = ST_ST_LAST_ACK;
            end else begin
                setStatus = ST_ST_DATA_ACK;
            end
        end else if ((startSeen || stopSeen) && (state_q == LS_RX || state_q == LS_TX)) begin
            setDone = 1'b1;
            setStatus = ST_STOP;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q <= LS_IDLE;
            bitCnt_q <= 3'h0;
            shift_q <= 8'h00;
            lastByte_q <= 1'b0;
            gcMode_q <= 1'b0;
        end else if (!enabled) begin
            state_q <= LS_IDLE;
        end else if (startSeen) begin
            state_q <= LS_ADDR; // monitoring continues with ack enable low
            bitCnt_q <= 3'h0;
        end else if (stopSeen) begin
            state_q <= LS_IDLE;
        end else begin
            case (state_q)
                LS_ADDR: if (sclRise) begin
                    shift_q <= {shift_q[6:0], sda};
                    bitCnt_q <= bitCnt_q + 3'h1;
                    if (bitCnt_q == 3'h7) begin
                        state_q <= LS_ADDR_ACK;
                    end
                end
                LS_ADDR_ACK: if (sclFall && ackPhase) begin
                    state_q <= shift_q[0] ? LS_TX : LS_RX;
                    bitCnt_q <= 3'h0;
                end else if (sclFall) begin
                    // ack only when enabled, recognises again on resume
                    if (ackEn && (ownHit || (gcHit && !shift_q[0]))) begin
                        gcMode_q <= gcHit && !ownHit;
                        lastByte_q <= !ackEn;
                        bitCnt_q <= 3'h1; // ack bit now on the bus
                    end else begin
                        state_q <= LS_IGNORE;
                    end
                end
                LS_RX: if (sclRise && !stretch_q) begin
                    shift_q <= {shift_q[6:0], sda};
                    bitCnt_q <= bitCnt_q + 3'h1;
                    if (bitCnt_q == 3'h7) begin
                        state_q <= LS_RX_ACK;
                        lastByte_q <= !ackEn;
                    end
                end
                LS_RX_ACK: if (sclFall && ackPhase) begin
                    state_q <= lastByte_q ? LS_IGNORE : LS_RX;
                    bitCnt_q <= 3'h0;
                end else if (sclFall) begin
                    bitCnt_q <= 3'h1; // ack bit now on the bus
                end
                LS_TX: if (sclFall && !stretch_q) begin
                    bitCnt_q <= bitCnt_q + 3'h1;
                    if (bitCnt_q == 3'h7) begin
                        state_q <= LS_TX_ACK;
                        lastByte_q <= !ackEn;
                    end
                end
                LS_TX_ACK: if (sclRise) begin
                    shift_q[0] <= sda; // master answer, acted on at the fall
                end else if (sclFall) begin
                    // last byte or nack leaves the slave not addressed
                    state_q <= (shift_q[0] || lastByte_q) ? LS_IGNORE : LS_TX;
                end
                default: ;
            endcase
        end
    end

    // data register; receive byte kept for software
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            data_q <= DATA_RESET;
        end else if (regWrite && isReg(regAddr, OFS_DATA) && ctrl_q[CTL_DONE]) begin
            data_q <= regWdata;
        end else if (state_q == LS_RX && sclRise && bitCnt_q == 3'h7 && !sleep_q) begin
            data_q <= {shift_q[6:0], sda}; // left stale in sleep
        end
    end

    // wake pulse and clock stretch after a sleeping match
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wakeUp <= 1'b0;
            wokeUp_q <= 1'b0;
        end else begin
            wakeUp <= sleep_q && setDone && state_q == LS_ADDR_ACK;
            if (wakeUp) begin
                wokeUp_q <= 1'b1;
            end else if (doneClear) begin
                wokeUp_q <= 1'b0;
            end
        end
    end

    // ***************************************************
    // pin drivers
    // ***************************************************
    wire txBit = (state_q == LS_TX) ? data_q[3'h7 - bitCnt_q] : 1'b1;
    // ack only between two falls, so data never moves while the clock is high
    wire ackLow = (state_q == LS_ADDR_ACK && ackPhase) || (state_q == LS_RX_ACK && ackPhase && !lastByte_q);
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            stretch_q <= 1'b0;
            sclOeN <= 1'b1;
            sdaOeN <= 1'b1;
        end else begin
            // stretch while flag is pending outside the ignore state, or from wake until cleared
            stretch_q <= (ctrl_q[CTL_DONE] && !doneClear && state_q != LS_IGNORE) || wokeUp_q || wakeUp;
            sclOeN <= !stretch_q;
            // ignore state leaves data released
            sdaOeN <= !(ackLow || (state_q == LS_TX && !txBit));
        end
    end
    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;

    // ***************************************************
    // checks
    // ***************************************************
    sequence addrDone_s;
        state_q == LS_ADDR_ACK && sclFall && ackPhase && ownHit;
    endsequence
    gc_nack_code_a: assert property (@(posedge mclk) disable iff (reset)
        (state_q == LS_RX_ACK && sclFall && ackPhase && gcMode_q && lastByte_q) |=> status_q == ST_GC_DATA_NACK)
        else $error("general call nack code wrong");
    stop_code_a: assert property (@(posedge mclk) disable iff (reset)
        (stopSeen && enabled && (state_q == LS_RX || state_q == LS_TX)) |=> status_q == ST_STOP && ctrl_q[CTL_DONE])
        else $error("stop code wrong");
    dir_select_a: assert property (@(posedge mclk) disable iff (reset)
        (addrDone_s and (startSeen == 1'b0 && stopSeen == 1'b0 && enabled)) |=>
        state_q == (shift_q[0] ? LS_TX : LS_RX))
        else $error("direction not honoured");
    addr_flag_a: assert property (@(posedge mclk) disable iff (reset)
        addrDone_s |=> ctrl_q[CTL_DONE])
        else $error("flag not set after address");
    arb_code_a: assert property (@(posedge mclk) disable iff (reset)
        (addrDone_s and (shift_q[0] && arbLost)) |=> status_q == ST_ST_ARB)
        else $error("arbitration code wrong");
    last_code_a: assert property (@(posedge mclk) disable iff (reset)
        (state_q == LS_TX_ACK && sclFall && !shift_q[0] && lastByte_q) |=> status_q == ST_ST_LAST_ACK)
        else $error("last byte ack code wrong");
    ignore_release_a: assert property (@(posedge mclk) disable iff (reset)
        $past(state_q) == LS_IGNORE && state_q == LS_IGNORE |=> sdaOeN)
        else $error("data driven while not addressed");
    wake_hold_a: assert property (@(posedge mclk) disable iff (reset)
        wakeUp |-> ##3 !sclOeN)
        else $error("clock not held after wake");
    tx_ack_code_a: assert property (@(posedge mclk) disable iff (reset)
        (state_q == LS_TX_ACK && sclFall && !shift_q[0] && !lastByte_q) |=> status_q == ST_ST_DATA_ACK)
        else $error("transmit ack code wrong");
endmodule : tws_slave

// ---- dv/tws_master_model.sv ----
// behavioural two-wire bus master that drives the pins from outside
module tws_master_model (
    // bus levels after the pull-ups
    input wire logic scl,
    input wire logic sda,
    // open-drain pulls, high pulls the line low
    output logic sclPull,
    output logic sdaPull
);
    timeunit 1ns;
    timeprecision 1ps;
    // lines released at time zero, the pull-ups make them high
    initial begin
        sclPull = 1'b0;
        sdaPull = 1'b0;
    end
    // one bit out; waiting on scl honours a slave that stretches the clock
    task automatic bitOut(input logic b);
        sdaPull = !b;
        #40;
        sclPull = 1'b0;
        wait (scl);
        #80;
        sclPull = 1'b1;
        #40;
    endtask : bitOut
    // one bit in, sampled in the middle of the high phase
    task automatic bitIn(output logic b);
        sdaPull = 1'b0;
        #40;
        sclPull = 1'b0;
        wait (scl);
        #40;
        b = sda;
        #40;
        sclPull = 1'b1;
        #40;
    endtask : bitIn
    // start, also usable as a repeated start
    task automatic start();
        sdaPull = 1'b0;
        #40;
        sclPull = 1'b0;
        wait (scl);
        #80;
        sdaPull = 1'b1;
        #80;
        sclPull = 1'b1;
        #40;
    endtask : start
    // stop; the bus is left idle with both lines released
    task automatic stop();
        sdaPull = 1'b1;
        #40;
        sclPull = 1'b0;
        wait (scl);
        #80;
        sdaPull = 1'b0;
        #80;
    endtask : stop
    // byte out, msb first, then the slave's answer
    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bitOut(d[i]);
        bitIn(a);
        ack = !a;
    endtask : sendByte
    // byte in, then our own ack or nack
    task automatic recvByte(input logic ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bitIn(d[i]);
        bitOut(!ack);
    endtask : recvByte
endmodule : tws_master_model

// ---- dv/tws_slave_tb.sv ----
// self-checking bench for the two-wire slave block
module tws_slave_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tws_pkg::*;
    // ****************
    // constants and signals
    // ****************
    localparam logic [7:0] EN = 8'h01 << CTL_EN;
    localparam logic [7:0] AK = 8'h01 << CTL_ACKEN;
    localparam logic [7:0] BEG = 8'h01 << CTL_BEGIN;
    localparam logic [7:0] CLR = 8'h01 << CTL_DONE;
    localparam int CEIL = 40000;
    typedef struct packed {
        logic [7:0] own;
        logic [7:0] ctl;
        logic [7:0] bus;
        logic ack;
        logic [7:0] st;
    } tws_row_type;
    tws_row_type rows [7] = '{
        '{8'h55, EN | AK, 8'h54, 1'b1, ST_SR_ADDR}, '{8'h55, EN | AK, 8'h00, 1'b1, ST_SR_GC},
        '{8'h54, EN | AK, 8'h00, 1'b0, ST_NONE}, '{8'h55, EN | AK, 8'h56, 1'b0, ST_NONE},
        '{8'h55, EN, 8'h54, 1'b0, ST_NONE}, '{8'h55, EN | AK, 8'h54, 1'b1, ST_SR_ADDR},
        '{8'h55, AK, 8'h54, 1'b0, ST_NONE}};
    logic mclk, reset, regWrite, regRead, arbLost, sclOut, sclOeN, sdaOut, sdaOeN;
    logic startRequest, wakeUp, sclPull, sdaPull, scl, sda, ack, k, begun;
    logic [2:0] regAddr;
    logic [7:0] regWdata, regRdata, run, got, b0, b1, b2;
    int mismatches = 0, nCompared = 0, cyc = 0, starts = 0, wakes = 0;
    // wired-and bus with pull-ups
    assign scl = !sclPull && (sclOeN || sclOut);
    assign sda = !sdaPull && (sdaOeN || sdaOut);
    tws_slave uut (.mclk(mclk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .sclIn(scl), .sdaIn(sda), .sclOut(sclOut), .sclOeN(sclOeN),
        .sdaOut(sdaOut), .sdaOeN(sdaOeN), .arbLost(arbLost), .startRequest(startRequest), .wakeUp(wakeUp));
    tws_master_model m (.scl(scl), .sda(sda), .sclPull(sclPull), .sdaPull(sdaPull));
    // clock, pulse counters and the hang guard
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        starts += (startRequest === 1'b1);
        wakes += (wakeUp === 1'b1);
        if (cyc == CEIL) begin
            mismatches++;
            results();
        end
    end
    // ****************
    // tasks
    // ****************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        nCompared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        @(negedge mclk);
        d = regRdata;
    endtask : rd
    // bounded poll: a flag that never comes shows up as status 0xf8
    task automatic expStat(input logic [7:0] code);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < 4000 && v[CTL_DONE] !== 1'b1; i++) rd(OFS_CTRL, v);
        rd(OFS_STATUS, v);
        chk(v, code);
    endtask : expStat
    // address write then stop, serviced by software when acked
    task automatic probe(input logic [7:0] a, input logic exp, input logic [7:0] st);
        fork
            begin
                m.start();
                m.sendByte(a, k);
                m.stop();
            end
            if (exp) begin
                expStat(st);
                wr(OFS_CTRL, run | CLR);
                expStat(ST_STOP);
                wr(OFS_CTRL, run | CLR);
            end
        join
        chk({7'h0, k}, {7'h0, exp});
    endtask : probe
    task automatic results();
        $display("compared %0d mismatches %0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    // ****************
    // main sequence
    // ****************
    initial begin
        {mclk, reset, regWrite, regRead, arbLost, regAddr, regWdata} = {2'b01, 14'h0};
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            wr(OFS_ADDR, rows[i].own);
            run = rows[i].ctl;
            wr(OFS_CTRL, run);
            probe(rows[i].bus, rows[i].ack, rows[i].st);
            rd(OFS_STATUS, got);
            chk(got, ST_NONE);
            $display("row %0d done", i);
        end
        run = EN | AK;
        wr(OFS_CTRL, run);
        // slave transmit, last byte by clearing ack enable, then master keeps clocking
        fork
            begin
                m.start();
                m.sendByte(8'h55, ack);
                m.recvByte(1'b1, b0);
                m.recvByte(1'b1, b1);
                m.recvByte(1'b0, b2);
                m.stop();
            end
            begin
                expStat(ST_ST_ADDR);
                wr(OFS_DATA, 8'ha5);
                wr(OFS_CTRL, run | CLR);
                expStat(ST_ST_DATA_ACK);
                wr(OFS_DATA, 8'h3c);
                wr(OFS_CTRL, EN | CLR);
                expStat(ST_ST_LAST_ACK);
                wr(OFS_CTRL, run | CLR);
            end
        join
        chk(b0, 8'ha5);
        chk(b1, 8'h3c);
        chk(b2, 8'hff);
        $display("transmit test done");
        // lost arbitration then read-addressed; single byte ends in nack
        @(posedge mclk);
        arbLost <= 1'b1;
        fork
            begin
                m.start();
                m.sendByte(8'h55, ack);
                m.recvByte(1'b0, b0);
                m.stop();
            end
            begin
                expStat(ST_ST_ARB);
                @(posedge mclk);
                arbLost <= 1'b0;
                wr(OFS_DATA, 8'h81);
                wr(OFS_CTRL, EN | CLR);
                expStat(ST_ST_DATA_NACK);
                wr(OFS_CTRL, run | CLR);
            end
        join
        chk(b0, 8'h81);
        $display("arbitration test done");
        // general-call byte refused, resume with a begin request
        begun = 1'b0;
        fork
            begin
                m.start();
                m.sendByte(8'h00, ack);
                m.sendByte(8'h77, k);
                // bus still busy: the begin request must wait for the stop
                wait (begun);
                repeat (20) @(posedge mclk);
                chk({7'h0, starts != 0}, 8'h00);
                m.stop();
            end
            begin
                expStat(ST_SR_GC);
                wr(OFS_CTRL, EN | CLR);
                expStat(ST_GC_DATA_NACK);
                rd(OFS_DATA, got);
                chk(got, 8'h77);
                starts = 0;
                wr(OFS_CTRL, run | BEG | CLR);
                begun = 1'b1;
            end
        join
        repeat (50) @(posedge mclk);
        chk({7'h0, k}, 8'h00);
        chk({7'h0, starts != 0}, 8'h01);
        wr(OFS_CTRL, run);
        $display("general call test done");
        // wake from sleep: clock held low until the flag is cleared
        wr(OFS_SLEEP, 8'h01);
        wakes = 0;
        fork
            begin
                m.start();
                m.sendByte(8'h54, ack);
                m.stop();
            end
            begin
                for (int i = 0; i < 4000 && wakes == 0; i++) @(posedge mclk);
                repeat (100) @(posedge mclk);
                chk({7'h0, scl}, 8'h00);
                chk({6'h0, sclOut, sdaOut}, 8'h00);
                expStat(ST_SR_ADDR);
                wr(OFS_CTRL, run | CLR);
                expStat(ST_STOP);
                wr(OFS_CTRL, run | CLR);
            end
        join
        chk({7'h0, wakes != 0}, 8'h01);
        rd(OFS_SLEEP, got);
        chk(got, 8'h00);
        $display("sleep test done");
        results();
    end
endmodule : tws_slave_tb
